// >>> msc_exec.sv
// command executor for stop, output, position and send-string commands.
// assumes a parser on clk delivers decoded commands, a motion generator on clk.
// Notes on behaviour
// - stop-jog while jogging decelerates with the jog decel rate.
// - stop-and-flush aborts the running queued command and empties the queue.
// - stop-and-flush without parameter decelerates with the max accel rate.
// - stop-and-flush with D uses feed decel for feeds, jog decel when jogging.
// - stop-current aborts only the running queued command; queue stays intact.
// - stop-current without parameter decelerates with the max accel rate.
// - stop-current with D uses feed decel for feeds, jog stop rate when jogging.
// - writing jog decel also overwrites jog stop rate.
// - set-output drives output 1; L is low (energized), H is high (open).
// - set-output is ignored while the output has a dedicated function.
// - a point reads low when current flows, high otherwise.
// - set-position loads the signed counter; query replies with equals sign.
// - send-string transmits up to 4 characters back to the host.
// - send-string transmits only after all earlier queued commands finish.
//
// The register offsets and the address-and-strobe port were left to the implementer.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module msc_exec #(
  parameter int RATE_W = 16,
  parameter int DEPTH = 8
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // decoded commands from the parser
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic [3:0] cmd_code,
  input wire logic cmd_d,
  input wire logic [2:0] cmd_len,
  input wire logic [31:0] cmd_arg,
  // reply bytes to the serial transmitter
  output logic reply_valid,
  input wire logic reply_ready,
  output logic [7:0] reply_data,
  // motion generator
  input wire logic motion_busy,
  input wire logic motion_jog,
  output logic move_start,
  output logic [31:0] move_arg,
  output logic stop_req,
  output logic [RATE_W-1:0] stop_rate,
  input wire logic step_pulse,
  input wire logic step_dir,
  // digital i/o pins
  input wire logic in_current,
  input wire logic func_level,
  output logic out_energize,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  localparam int CNT_W = $clog2(DEPTH + 1);

  // nibble to ascii hex
  function automatic logic [7:0] hex_char(input logic [3:0] n);
    hex_char = (n < 4'ha) ? (8'h30 + {4'h0, n}) : (8'h57 + {4'h0, n});
  endfunction : hex_char

  // stop deceleration choice: D selects feed or jog rate, else max accel
  function automatic logic [RATE_W-1:0] pick_rate(input logic use_d, input logic jog,
      input logic [RATE_W-1:0] jog_r, input logic [RATE_W-1:0] feed_r,
      input logic [RATE_W-1:0] max_r);
    pick_rate = !use_d ? max_r : (jog ? jog_r : feed_r);
  endfunction : pick_rate

  ////////////////////////////////////////////////////////////////////////////////
  // command classification
  logic is_imm, imm_take, buf_take, is_halt, is_flush, is_sjog;
  logic q_push_ready, q_valid, q_pop, flush;
  logic [msc_pkg::ENTRY_W-1:0] q_data;
  logic [CNT_W-1:0] q_count;
  logic [3:0] e_code;
  logic e_d;
  logic [2:0] e_len;
  logic [31:0] e_arg;

  assign is_sjog = (cmd_code == msc_pkg::CMD_STOP_JOG);
  assign is_halt = (cmd_code == msc_pkg::CMD_HALT_CUR);
  assign is_flush = (cmd_code == msc_pkg::CMD_STOP_FLUSH);
  assign is_imm = is_sjog || is_halt || is_flush;
  assign cmd_ready = is_imm || q_push_ready; // immediates never wait
  assign imm_take = cmd_valid && is_imm;
  assign buf_take = cmd_valid && !is_imm;
  assign flush = imm_take && is_flush;
  assign e_code = q_data[msc_pkg::CODE_LSB +: 4];
  assign e_d = q_data[msc_pkg::D_BIT];
  assign e_len = q_data[msc_pkg::LEN_LSB +: 3];
  assign e_arg = q_data[31:0];

  // buffered commands wait here in arrival order
  msc_cmd_queue #(
    .WIDTH(msc_pkg::ENTRY_W),
    .DEPTH(DEPTH),
    .CNT_W(CNT_W)
  ) u_queue (
    .clk(clk),
    .rst_b(rst_b),
    .push_valid(buf_take),
    .push_ready(q_push_ready),
    .push_data({cmd_code, cmd_d, cmd_len, cmd_arg}),
    .pop_valid(q_valid),
    .pop_ready(q_pop),
    .pop_data(q_data),
    .flush(flush),
    .count(q_count)
  );

  ////////////////////////////////////////////////////////////////////////////////
  // register file
  logic [RATE_W-1:0] jog_decel_rate_q, jog_decel_rate_d, jog_stop_rate_q, jog_stop_rate_d;
  logic [RATE_W-1:0] max_accel_rate_q, max_accel_rate_d, feed_slowdown_rate_q, feed_slowdown_rate_d;
  logic [1:0] out_func_q, out_func_d;
  logic [31:0] rdata_q, rdata_d;
  logic [31:0] pos_q, pos_d;
  logic out_level_q, out_level_d;
  logic in_sync1_q, in_sync2_q;
  msc_pkg::msc_state_e st_q, st_d;

  // register writes and read data, answered one cycle later
  always_comb begin
    jog_decel_rate_d = jog_decel_rate_q;
    jog_stop_rate_d = jog_stop_rate_q;
    max_accel_rate_d = max_accel_rate_q;
    feed_slowdown_rate_d = feed_slowdown_rate_q;
    out_func_d = out_func_q;
    rdata_d = '0;
    if (reg_wr) begin
      case (reg_addr)
        msc_pkg::REG_JOG_DECEL: begin
          jog_decel_rate_d = reg_wdata[RATE_W-1:0];
          jog_stop_rate_d = reg_wdata[RATE_W-1:0];
        end
        msc_pkg::REG_JOG_STOP: jog_stop_rate_d = reg_wdata[RATE_W-1:0];
        msc_pkg::REG_MAX_ACCEL: max_accel_rate_d = reg_wdata[RATE_W-1:0];
        msc_pkg::REG_FEED_SLOW: feed_slowdown_rate_d = reg_wdata[RATE_W-1:0];
        msc_pkg::REG_OUT_FUNC: out_func_d = reg_wdata[1:0];
        default: ;
      endcase
    end
    if (reg_rd) begin
      case (reg_addr)
        msc_pkg::REG_JOG_DECEL: rdata_d = 32'(jog_decel_rate_q);
        msc_pkg::REG_JOG_STOP: rdata_d = 32'(jog_stop_rate_q);
        msc_pkg::REG_MAX_ACCEL: rdata_d = 32'(max_accel_rate_q);
        msc_pkg::REG_FEED_SLOW: rdata_d = 32'(feed_slowdown_rate_q);
        msc_pkg::REG_OUT_FUNC: rdata_d = {30'h0, out_func_q};
        // out level and input level are high when no current
        msc_pkg::REG_STATUS: rdata_d = {16'h0, 8'(q_count), 3'h0, st_q, motion_busy,
                                        !in_sync2_q, out_level_q};
        msc_pkg::REG_POSITION: rdata_d = pos_q;
        default: rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      jog_decel_rate_q <= msc_pkg::RATE_RST;
      jog_stop_rate_q <= msc_pkg::RATE_RST;
      max_accel_rate_q <= msc_pkg::RATE_RST;
      feed_slowdown_rate_q <= msc_pkg::RATE_RST;
      out_func_q <= msc_pkg::FUNC_GENERAL;
      rdata_q <= '0;
    end else begin
      jog_decel_rate_q <= jog_decel_rate_d;
      jog_stop_rate_q <= jog_stop_rate_d;
      max_accel_rate_q <= max_accel_rate_d;
      feed_slowdown_rate_q <= feed_slowdown_rate_d;
      out_func_q <= out_func_d;
      rdata_q <= rdata_d;
    end
  end
  assign reg_rdata = rdata_q;

  ////////////////////////////////////////////////////////////////////////////////
  // input pin synchroniser; pin high means current flows, inverted only after both flops
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      in_sync1_q <= 1'b0;
      in_sync2_q <= 1'b0;
    end else begin
      in_sync1_q <= in_current;
      in_sync2_q <= in_sync1_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // immediate stop requests
  logic stop_q, stop_d;
  logic [RATE_W-1:0] rate_q, rate_d;

  always_comb begin
    stop_d = 1'b0;
    rate_d = rate_q;
    if (imm_take && motion_busy) begin
      if (is_sjog && motion_jog) begin
        stop_d = 1'b1;
        rate_d = jog_decel_rate_q;
      end else if (is_halt) begin
        stop_d = 1'b1;
        rate_d = pick_rate(cmd_d, motion_jog, jog_stop_rate_q, feed_slowdown_rate_q,
                           max_accel_rate_q);
      end else if (is_flush) begin
        stop_d = 1'b1;
        rate_d = pick_rate(cmd_d, motion_jog, jog_decel_rate_q, feed_slowdown_rate_q,
                           max_accel_rate_q);
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      stop_q <= 1'b0;
      rate_q <= '0;
    end else begin
      stop_q <= stop_d;
      rate_q <= rate_d;
    end
  end
  assign stop_req = stop_q;
  assign stop_rate = rate_q;

  ////////////////////////////////////////////////////////////////////////////////
  // queued command execution, reply buffer, output and position
  logic [7:0] tx_buf_q [msc_pkg::REPLY_MAX];
  logic [7:0] tx_buf_d [msc_pkg::REPLY_MAX];
  logic [3:0] tx_cnt_q, tx_cnt_d, tx_idx_q, tx_idx_d;
  logic start_q, start_d;
  logic [31:0] marg_q, marg_d;
  logic abort;

  assign abort = imm_take && (is_halt || is_flush);
  assign q_pop = (st_q == msc_pkg::ST_IDLE) && q_valid && !flush; // in order

  always_comb begin
    st_d = st_q;
    tx_buf_d = tx_buf_q;
    tx_cnt_d = tx_cnt_q;
    tx_idx_d = tx_idx_q;
    start_d = 1'b0;
    marg_d = marg_q;
    out_level_d = out_level_q;
    pos_d = pos_q;
    if (step_pulse) pos_d = step_dir ? pos_q + 32'h1 : pos_q - 32'h1;
    case (st_q)
      msc_pkg::ST_IDLE: begin
        if (q_pop) begin
          case (e_code)
            msc_pkg::CMD_SET_OUT: begin
              // only output 1 exists; dedicated use blocks it
              if (e_arg[7:0] == 8'h01 && out_func_q == msc_pkg::FUNC_GENERAL)
                out_level_d = e_d;
            end
            msc_pkg::CMD_SET_POS: pos_d = e_arg;
            msc_pkg::CMD_GET_POS: begin
              tx_buf_d[0] = msc_pkg::CHAR_EQUALS;
              for (int i = 0; i < 8; i++) tx_buf_d[i+1] = hex_char(pos_q[28-4*i +: 4]);
              tx_cnt_d = msc_pkg::POS_REPLY_LEN;
              tx_idx_d = '0;
              st_d = msc_pkg::ST_SEND;
            end
            msc_pkg::CMD_SEND_STR: begin
              // characters packed first-in-high
              for (int i = 0; i < msc_pkg::STR_MAX; i++) tx_buf_d[i] = e_arg[24-8*i +: 8];
              tx_cnt_d = (e_len > 3'd4) ? 4'd4 : {1'b0, e_len};
              tx_idx_d = '0;
              st_d = (e_len == 3'd0) ? msc_pkg::ST_IDLE : msc_pkg::ST_SEND;
            end
            msc_pkg::CMD_MOVE: begin
              start_d = 1'b1;
              marg_d = e_arg;
              st_d = msc_pkg::ST_ARM;
            end
            default: ; // unknown entries retire silently
          endcase
        end
      end
      msc_pkg::ST_ARM: st_d = msc_pkg::ST_MOVE; // motion picks up the start
      msc_pkg::ST_MOVE: if (!motion_busy) st_d = msc_pkg::ST_IDLE;
      msc_pkg::ST_SEND: begin
        if (reply_ready) begin
          tx_idx_d = tx_idx_q + 4'h1;
          if (tx_idx_q + 4'h1 == tx_cnt_q) st_d = msc_pkg::ST_IDLE;
        end
      end
      default: st_d = msc_pkg::ST_IDLE;
    endcase
    if (abort) begin
      st_d = msc_pkg::ST_IDLE;
      start_d = 1'b0;
      tx_cnt_d = '0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= msc_pkg::ST_IDLE;
      for (int i = 0; i < msc_pkg::REPLY_MAX; i++) tx_buf_q[i] <= '0;
      tx_cnt_q <= '0;
      tx_idx_q <= '0;
      start_q <= 1'b0;
      marg_q <= '0;
      out_level_q <= msc_pkg::OUT_LEVEL_RST;
      pos_q <= '0;
    end else begin
      st_q <= st_d;
      tx_buf_q <= tx_buf_d;
      tx_cnt_q <= tx_cnt_d;
      tx_idx_q <= tx_idx_d;
      start_q <= start_d;
      marg_q <= marg_d;
      out_level_q <= out_level_d;
      pos_q <= pos_d;
    end
  end

  // outputs; low level means energized
  assign move_start = start_q;
  assign move_arg = marg_q;
  assign reply_valid = (st_q == msc_pkg::ST_SEND); // only replies
  assign reply_data = tx_buf_q[tx_idx_q];
  assign out_energize = (out_func_q == msc_pkg::FUNC_GENERAL) ? !out_level_q : func_level;

  ////////////////////////////////////////////////////////////////////////////////
  // checks
  sequence s_flush_cmd;
    cmd_valid && is_flush;
  endsequence
  sequence s_halt_cmd;
    cmd_valid && is_halt;
  endsequence

  a_jog_stop_rate: assert property (@(posedge clk) disable iff (!rst_b)
    cmd_valid && is_sjog && motion_busy && motion_jog |=> stop_req && stop_rate == $past(jog_decel_rate_q))
    else $error("stop-jog did not use jog decel rate");
  a_flush_empties: assert property (@(posedge clk) disable iff (!rst_b)
    s_flush_cmd |=> q_count == '0 && st_q == msc_pkg::ST_IDLE && !reply_valid)
    else $error("flush left commands behind");
  a_flush_max_rate: assert property (@(posedge clk) disable iff (!rst_b)
    s_flush_cmd ##0 (motion_busy && !cmd_d) |=> stop_req && stop_rate == $past(max_accel_rate_q))
    else $error("flush without D did not use max accel");
  a_flush_d_rate: assert property (@(posedge clk) disable iff (!rst_b)
    s_flush_cmd ##0 (motion_busy && cmd_d) |=>
      stop_rate == ($past(motion_jog) ? $past(jog_decel_rate_q) : $past(feed_slowdown_rate_q)))
    else $error("flush with D used wrong rate");
  a_halt_keeps_queue: assert property (@(posedge clk) disable iff (!rst_b)
    s_halt_cmd ##0 (st_q != msc_pkg::ST_IDLE) |=> q_count == $past(q_count) && st_q == msc_pkg::ST_IDLE)
    else $error("stop-current disturbed the queue");
  a_halt_rate: assert property (@(posedge clk) disable iff (!rst_b)
    s_halt_cmd ##0 motion_busy |=> stop_req && stop_rate == ($past(cmd_d) ?
      ($past(motion_jog) ? $past(jog_stop_rate_q) : $past(feed_slowdown_rate_q)) : $past(max_accel_rate_q)))
    else $error("stop-current used wrong rate");
  a_jog_write_both: assert property (@(posedge clk) disable iff (!rst_b)
    reg_wr && reg_addr == msc_pkg::REG_JOG_DECEL |=> jog_stop_rate_q == jog_decel_rate_q)
    else $error("jog decel write missed jog stop rate");
  a_out_blocked: assert property (@(posedge clk) disable iff (!rst_b)
    out_func_q != msc_pkg::FUNC_GENERAL |=> out_level_q == $past(out_level_q))
    else $error("output changed under dedicated function");
  a_pos_load: assert property (@(posedge clk) disable iff (!rst_b)
    q_pop && e_code == msc_pkg::CMD_SET_POS |=> pos_q == $past(e_arg))
    else $error("position not loaded");
  a_send_order: assert property (@(posedge clk) disable iff (!rst_b)
    reply_valid && !$past(reply_valid) |-> $past(q_pop) && $past(st_q) == msc_pkg::ST_IDLE)
    else $error("reply started without an in-order pop");
endmodule : msc_exec
`default_nettype wire

// >>> msc_queue.sv
// package of shared constants for the stop/output/position command executor,
// and the command queue that holds buffered commands in arrival order.
// assumes one clock domain and an upstream parser delivering decoded commands.
package msc_pkg;
  // command codes as delivered by the parser
  localparam logic [3:0] CMD_STOP_JOG = 4'h1;   // stop_jog_cmd, immediate
  localparam logic [3:0] CMD_HALT_CUR = 4'h2;   // halt_current_cmd, immediate
  localparam logic [3:0] CMD_STOP_FLUSH = 4'h3; // stop_flush_cmd, immediate
  localparam logic [3:0] CMD_SET_OUT = 4'h4;    // queued
  localparam logic [3:0] CMD_SET_POS = 4'h5;    // set_position_cmd with value, queued
  localparam logic [3:0] CMD_GET_POS = 4'h6;    // set_position_cmd without value, queued
  localparam logic [3:0] CMD_SEND_STR = 4'h7;   // queued
  localparam logic [3:0] CMD_MOVE = 4'h8;       // feed-type move, queued
  // queue entry layout: {code, has_d, len, arg}
  localparam int ENTRY_W = 40;
  localparam int CODE_LSB = 36;
  localparam int D_BIT = 35;
  localparam int LEN_LSB = 32;
  // register byte addresses
  localparam logic [7:0] REG_JOG_DECEL = 8'h00;
  localparam logic [7:0] REG_JOG_STOP = 8'h04;
  localparam logic [7:0] REG_MAX_ACCEL = 8'h08;
  localparam logic [7:0] REG_FEED_SLOW = 8'h0c;
  localparam logic [7:0] REG_OUT_FUNC = 8'h10;
  localparam logic [7:0] REG_STATUS = 8'h14;
  localparam logic [7:0] REG_POSITION = 8'h18;
  // output function select values
  localparam logic [1:0] FUNC_GENERAL = 2'h0;
  // reset values
  localparam logic [15:0] RATE_RST = 16'h0064;
  localparam logic OUT_LEVEL_RST = 1'b1; // high = open, no current
  // reply framing
  localparam logic [7:0] CHAR_EQUALS = 8'h3d;
  localparam logic [3:0] POS_REPLY_LEN = 4'h9;
  localparam int REPLY_MAX = 9;
  localparam int STR_MAX = 4;
  // executor states, gray along idle-arm-move
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_MOVE = 2'b11,
    ST_SEND = 2'b10
  } msc_state_e;
endpackage : msc_pkg

`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module msc_cmd_queue #(
  parameter int WIDTH = 40,
  parameter int DEPTH = 8,
  parameter int CNT_W = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // fill side
  input wire logic push_valid,
  output logic push_ready,
  input wire logic [WIDTH-1:0] push_data,
  // drain side
  output logic pop_valid,
  input wire logic pop_ready,
  output logic [WIDTH-1:0] pop_data,
  // discard everything
  input wire logic flush,
  output logic [CNT_W-1:0] count
);
  localparam int PTR_W = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PTR_W-1:0] wr_q, wr_d, rd_q, rd_d;
  logic [CNT_W-1:0] cnt_q, cnt_d;
  logic do_push, do_pop;

  // handshake terms
  assign push_ready = (cnt_q != CNT_W'(DEPTH));
  assign pop_valid = (cnt_q != '0);
  assign pop_data = mem_q[rd_q];
  assign count = cnt_q;
  assign do_push = push_valid && push_ready && !flush;
  assign do_pop = pop_valid && pop_ready && !flush;

  // pointer and count update
  always_comb begin
    wr_d = wr_q;
    rd_d = rd_q;
    cnt_d = cnt_q;
    if (flush) begin
      rd_d = wr_q;
      cnt_d = '0;
    end else begin
      if (do_push) wr_d = PTR_W'((wr_q + 1) % DEPTH);
      if (do_pop) rd_d = PTR_W'((rd_q + 1) % DEPTH);
      cnt_d = cnt_q + CNT_W'(do_push) - CNT_W'(do_pop);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      wr_q <= wr_d;
      rd_q <= rd_d;
      cnt_q <= cnt_d;
    end
  end

  // storage, no reset needed
  always_ff @(posedge clk) begin
    if (do_push) mem_q[wr_q] <= push_data;
  end
endmodule : msc_cmd_queue
`default_nettype wire

// >>> msc_motion_model.sv
// motion generator stand-in for the command executor bench.
// assumes move_start, stop_req and jog_go are one-cycle pulses on clk.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module msc_motion_model #(
  parameter int MOVE_LEN = 20
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // requests from executor and bench
  input wire logic move_start,
  input wire logic stop_req,
  input wire logic jog_go,
  // motion state
  output logic motion_busy,
  output logic motion_jog,
  output logic step_pulse
);
  logic [7:0] cnt_q;
  // feeds count down, jogs hold at full count, a stop cuts to a short ramp
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_q <= 8'h00;
      motion_jog <= 1'b0;
    end else if (stop_req) begin
      cnt_q <= 8'h03;
    end else if (move_start || jog_go) begin
      cnt_q <= jog_go ? 8'hff : 8'(MOVE_LEN);
      motion_jog <= jog_go;
    end else if (cnt_q != 8'h00 && cnt_q != 8'hff) begin
      cnt_q <= cnt_q - 8'h01;
    end
  end
  // one step per busy cycle moves the position counter
  assign motion_busy = cnt_q != 8'h00;
  assign step_pulse = motion_busy;
endmodule : msc_motion_model
`default_nettype wire

// >>> testbench.sv
// self-checking bench for the stop, output, position and send-string executor.
// assumes msc_exec and msc_motion_model are compiled before it.
`timescale 1ns/10ps
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module testbench;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic [3:0] cmd_code = 4'h0;
  logic cmd_d = 1'b0;
  logic [2:0] cmd_len = 3'h0;
  logic [31:0] cmd_arg = 32'h0;
  logic reply_valid;
  logic reply_ready = 1'b0;
  logic [7:0] reply_data;
  logic motion_busy;
  logic motion_jog;
  logic move_start;
  logic stop_req;
  logic step_pulse;
  logic jog_go = 1'b0;
  logic [31:0] move_arg;
  logic [15:0] stop_rate;
  logic [15:0] last_rate = 16'h0;
  logic in_current = 1'b0;
  logic func_level = 1'b0;
  logic out_energize;
  logic [7:0] reg_addr = 8'h0;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  logic [31:0] rd_v;
  logic [7:0] rq[$];
  int num_errors = 0;
  int n_checks = 0;
  int n_stops = 0;
  int n_exp = 0;
  // stop table: code, d letter, jogging, expected rate
  logic [3:0] t_code[6] = '{4'h1, 4'h2, 4'h3, 4'h2, 4'h2, 4'h3};
  logic t_d[6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
  logic t_jog[6] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0};
  logic [15:0] t_rate[6] = '{16'h20, 16'h30, 16'h20, 16'h40, 16'h50, 16'h50};
  logic [31:0] t_pos[2] = '{32'h7fffffff, 32'h80000001};

  always #2 clk = ~clk;

  msc_exec #(.RATE_W(16), .DEPTH(8)) uut (.clk(clk), .rst_b(rst_b), .cmd_valid(cmd_valid),
    .cmd_ready(cmd_ready), .cmd_code(cmd_code), .cmd_d(cmd_d), .cmd_len(cmd_len), .cmd_arg(cmd_arg),
    .reply_valid(reply_valid), .reply_ready(reply_ready), .reply_data(reply_data),
    .motion_busy(motion_busy), .motion_jog(motion_jog), .move_start(move_start), .move_arg(move_arg),
    .stop_req(stop_req), .stop_rate(stop_rate), .step_pulse(step_pulse), .step_dir(1'b1),
    .in_current(in_current), .func_level(func_level), .out_energize(out_energize),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));

  msc_motion_model #(.MOVE_LEN(20)) motion (.clk(clk), .rst_b(rst_b), .move_start(move_start),
    .stop_req(stop_req), .jog_go(jog_go), .motion_busy(motion_busy), .motion_jog(motion_jog),
    .step_pulse(step_pulse));

  ////////////////////////////////////////////////////////////////////////////////
  // slow reply sink and stop monitor
  always @(posedge clk) begin
    reply_ready <= ~reply_ready;
    if (reply_valid && reply_ready) rq.push_back(reply_data);
    if (stop_req) begin
      last_rate <= stop_rate;
      n_stops <= n_stops + 1;
    end
  end

  task automatic print_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask : print_verdict

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    n_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("BAD t=%0t %s seen %h want %h", $time, what, seen, exp);
    end
  endtask : chk

  // the monitor registers a stop on the edge at which the command returns; count proves it is fresh
  task automatic chk_stop(input logic [15:0] r);
    @(posedge clk);
    n_exp++;
    chk(n_stops, n_exp, "stop count");
    chk(32'(last_rate), 32'(r), "stop rate");
  endtask : chk_stop

  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask : cyc

  task automatic reg_w(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask : reg_w

  // read data is taken in the cycle after the strobe only
  task automatic reg_r(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 rd_v = reg_rdata;
    @(posedge clk);
  endtask : reg_r

  task automatic cmd(input logic [3:0] c, input logic d, input logic [2:0] l, input logic [31:0] a);
    int i;
    cmd_code <= c;
    cmd_d <= d;
    cmd_len <= l;
    cmd_arg <= a;
    cmd_valid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (cmd_ready === 1'b1) break;
    end
    cmd_valid <= 1'b0;
    @(posedge clk);
    if (i == 50) begin
      chk(1, 0, "command never taken");
      print_verdict;
    end
  endtask : cmd

  task automatic wait_busy(input logic v);
    int i;
    for (i = 0; i < 300 && motion_busy !== v; i++) @(posedge clk);
    if (i == 300) begin
      chk(1, 0, "motion wait ran out");
      print_verdict;
    end
  endtask : wait_busy

  task automatic chk_reply(input string s);
    chk(rq.size(), s.len(), "reply length");
    for (int i = 0; i < s.len() && i < rq.size(); i++) chk(32'(rq[i]), 32'(s[i]), "reply byte");
    rq.delete();
  endtask : chk_reply

  ////////////////////////////////////////////////////////////////////////////////
  // hang guard
  initial begin
    #320000;
    chk(1, 0, "run timed out");
    print_verdict;
  end

  // main sequence
  initial begin
    repeat (16) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    chk(32'(out_energize), 0, "output reset");
    chk(32'(stop_rate), 0, "rate reset");
    for (int i = 0; i < 4; i++) begin
      reg_r(8'(i * 4));
      chk(rd_v, 32'h64, "rate reset value");
    end
    reg_w(8'hf0, 32'h1234);
    reg_r(8'hf0);
    chk(rd_v, 0, "unmapped read");
    reg_w(msc_pkg::REG_JOG_STOP, 32'h55);
    reg_w(msc_pkg::REG_JOG_DECEL, 32'h20);
    reg_r(msc_pkg::REG_JOG_STOP);
    chk(rd_v, 32'h20, "jog stop follows jog decel");
    reg_w(msc_pkg::REG_JOG_STOP, 32'h30);
    reg_r(msc_pkg::REG_JOG_DECEL);
    chk(rd_v, 32'h20, "jog decel kept");
    reg_w(msc_pkg::REG_MAX_ACCEL, 32'h40);
    reg_w(msc_pkg::REG_FEED_SLOW, 32'h50);
    reg_w(msc_pkg::REG_POSITION, 32'h77);
    reg_r(msc_pkg::REG_POSITION);
    chk(rd_v, 0, "position read-only");
    // output levels and input reporting
    in_current <= 1'b1;
    cmd(msc_pkg::CMD_SET_OUT, 1'b0, 3'h0, 32'h1);
    cyc(3);
    chk(32'(out_energize), 1, "output low");
    reg_r(msc_pkg::REG_STATUS);
    chk(32'(rd_v[1:0]), 0, "levels low");
    in_current <= 1'b0;
    cmd(msc_pkg::CMD_SET_OUT, 1'b1, 3'h0, 32'h1);
    cmd(msc_pkg::CMD_SET_OUT, 1'b0, 3'h0, 32'h2);
    cyc(3);
    chk(32'(out_energize), 0, "output high");
    reg_r(msc_pkg::REG_STATUS);
    chk(32'(rd_v[1:0]), 3, "levels high");
    reg_w(msc_pkg::REG_OUT_FUNC, 32'h1);
    cmd(msc_pkg::CMD_SET_OUT, 1'b0, 3'h0, 32'h1);
    cyc(3);
    chk(32'(out_energize), 0, "dedicated output ignores set");
    func_level <= 1'b1;
    cyc(3);
    chk(32'(out_energize), 1, "dedicated output follows function");
    reg_w(msc_pkg::REG_OUT_FUNC, 32'h0);
    chk(32'(out_energize), 0, "dedicated set left no trace");
    chk(rq.size(), 0, "write-only silent");
    // position load at the top of the range and one above the bottom, and query reply
    foreach (t_pos[k]) begin
      cmd(msc_pkg::CMD_SET_POS, 1'b0, 3'h0, t_pos[k]);
      cmd(msc_pkg::CMD_GET_POS, 1'b0, 3'h0, 32'h0);
      cyc(30);
      reg_r(msc_pkg::REG_POSITION);
      chk(rd_v, t_pos[k], "position load");
      chk_reply($sformatf("=%h", t_pos[k]));
    end
    // string waits for the feed, length clipped to four
    cmd(msc_pkg::CMD_MOVE, 1'b0, 3'h0, 32'h1000);
    cmd(msc_pkg::CMD_SEND_STR, 1'b0, 3'h7, 32'h646f6e65);
    wait_busy(1'b1);
    chk(move_arg, 32'h1000, "move argument");
    wait_busy(1'b0);
    chk(rq.size(), 0, "string held behind move");
    cyc(30); // host stays quiet until the string is back
    chk_reply("done");
    // stop-current keeps the queue, stop-and-flush empties it
    for (int f = 0; f < 2; f++) begin
      cmd(msc_pkg::CMD_MOVE, 1'b0, 3'h0, 32'h0);
      cmd(msc_pkg::CMD_SEND_STR, 1'b0, 3'h2, 32'h6f6b0000);
      wait_busy(1'b1);
      cmd(f ? msc_pkg::CMD_STOP_FLUSH : msc_pkg::CMD_HALT_CUR, 1'b0, 3'h0, 32'h0);
      chk_stop(16'h40);
      wait_busy(1'b0);
      cyc(30);
      chk_reply(f ? "" : "ok");
    end
    reg_r(msc_pkg::REG_STATUS);
    chk(32'(rd_v[15:8]), 0, "queue empty after flush");
    // stop rates for jogs with and without the D letter and for feeds with it
    for (int j = 0; j < 6; j++) begin
      jog_go <= t_jog[j];
      if (!t_jog[j]) cmd(msc_pkg::CMD_MOVE, 1'b0, 3'h0, 32'h0);
      @(posedge clk);
      jog_go <= 1'b0;
      wait_busy(1'b1);
      cmd(t_code[j], t_d[j], 3'h0, 32'h0);
      chk_stop(t_rate[j]);
      wait_busy(1'b0);
    end
    print_verdict;
  end
endmodule : testbench
`default_nettype wire
